// ---- inc/setpoint_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the set-point registers
`ifndef SETPOINT_CFG_SVH
`define SETPOINT_CFG_SVH

`define SUBADDR_W            8
`define DATA_W               8
`define CODE_W               6
`define MV_W                 12

`define BUCK2_SUBADDR        8'h17
`define BUCK3_SUBADDR        8'h18
`define BUCKBOOST_SUBADDR    8'h19

`define BUCK2_RESET          8'h99
`define BUCK3_RESET          8'h8c
`define BUCKBOOST_RESET      8'hb2

`define PSE_BIT              7
`define RSVD_BIT             6
`define CODE_MSB             5
`define CODE_LSB             0

// Buck2 code map: 10 mV steps up to the knee, then 25 mV steps
`define BUCK2_KNEE           6'h32
`define BUCK2_BASE_MV        12'd850
`define BUCK2_STEP1_MV       12'd10
`define BUCK2_HIGH_MV        12'd1375
`define BUCK2_STEP2_MV       12'd25

// Buck3 code map: 25 mV steps up to the knee, then 50 mV steps
`define BUCK3_KNEE           6'h1a
`define BUCK3_BASE_MV        12'd900
`define BUCK3_STEP1_MV       12'd25
`define BUCK3_HIGH_MV        12'd1600
`define BUCK3_STEP2_MV       12'd50

// Buck-boost code map: 25 mV then 50 mV steps, codes above the top are reserved
`define BB_KNEE              6'h0f
`define BB_BASE_MV           12'd1175
`define BB_STEP1_MV          12'd25
`define BB_HIGH_MV           12'd1600
`define BB_STEP2_MV          12'd50
`define BB_TOP_CODE          6'h34

// Monitor blanking after a set-point write
`define CLK_MHZ              200
`define BLANK_TIME_MS        5
`define BLANK_CYCLES         (`BLANK_TIME_MS * `CLK_MHZ * 1000)

// Cycles the strap synchroniser needs before its output is trusted
`define STRAP_SETTLE         2'd3

`endif

// ---- inc/setpoint_pkg.sv ----
// Types shared by the converter set-point register logic
package setpoint_pkg;

   typedef enum logic [1:0] {
      KIND_BUCK2     = 2'b00,
      KIND_BUCK3     = 2'b01,
      KIND_BUCKBOOST = 2'b10
   } conv_kind_t;

   typedef enum logic [1:0] {
      STRAP_WAIT = 2'b00,
      STRAP_LOAD = 2'b01,
      STRAP_DONE = 2'b10
   } strap_state_t;

endpackage

// ---- test/converter_setpoint_registers_sva.sv ----
// Port-level assertions for the converter set-point registers
`timescale 1ns/1ps
module setpoint_checker #(
   parameter int unsigned BLANK_CYCLES = 20
) (
   input wire logic        clk,
   input wire logic        reset_n,
   input wire logic        ce,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [7:0]  subaddr,
   input wire logic [7:0]  wdata,
   input wire logic        write_unlocked,
   input wire logic        ready_ff,
   input wire logic [7:0]  rdata_ff,
   input wire logic        wr_done_ff,
   input wire logic [2:0]  pulse_skip_enable_ff,
   input wire logic [5:0]  buck3_voltage_code_ff,
   input wire logic [11:0] buck3_mv_ff,
   input wire logic [5:0]  buckboost_voltage_code_ff,
   input wire logic [11:0] buckboost_mv_ff,
   input wire logic        buckboost_reserved_ff,
   input wire logic [2:0]  blanking_ff,
   input wire logic [2:0]  ov_out_ff,
   input wire logic [2:0]  uv_out_ff
);
   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);
   logic        acc;
   logic [11:0] b3_exp;
   logic [31:0] cnt_ff;
   assign acc = ce && wr_en && write_unlocked && ready_ff && subaddr inside {[8'h17:8'h19]};
   assign b3_exp = (buck3_voltage_code_ff <= 6'h1a)
      ? 12'd900 + 12'd25 * buck3_voltage_code_ff
      : 12'd1600 + 12'd50 * (buck3_voltage_code_ff - 6'h1b);
   // Cycles the buck-boost blanking has stood since its last start
   always_ff @(posedge clk) begin
      if (!reset_n)
         cnt_ff <= '0;
      else if (ce)
         cnt_ff <= ((acc && subaddr == 8'h19) || !blanking_ff[2]) ? '0 : cnt_ff + 1;
   end
   wr_take_a:
      assert property (acc && subaddr == 8'h18 |=> wr_done_ff &&
         buck3_voltage_code_ff == $past(wdata[5:0])) else $error("buck3 write lost");
   refuse_a:
      assert property (ce && wr_en && !(write_unlocked && ready_ff) |=> !wr_done_ff &&
         $stable(buck3_voltage_code_ff)) else $error("refused write took effect");
   pse_write_a:
      assert property (acc && subaddr == 8'h19 |=> pulse_skip_enable_ff[2] == $past(wdata[7]))
         else $error("pulse skip bit wrong");
   blank_start_a:
      assert property (acc && subaddr == 8'h18 |=> blanking_ff[1] && !ov_out_ff[1] &&
         !uv_out_ff[1]) else $error("buck3 blanking missing");
   blank_max_a:
      assert property (blanking_ff[2] |-> cnt_ff <= BLANK_CYCLES)
         else $error("blanking too long");
   blank_len_a:
      assert property ($fell(blanking_ff[2]) |-> $past(cnt_ff) == BLANK_CYCLES)
         else $error("blanking too short");
   read_back_a:
      assert property (ce && rd_en && subaddr == 8'h18 |=> rdata_ff ==
         {$past(pulse_skip_enable_ff[1]), 1'b0, $past(buck3_voltage_code_ff)})
         else $error("buck3 read wrong");
   b3_mv_a:
      assert property (ready_ff && $stable(buck3_voltage_code_ff) |-> buck3_mv_ff == b3_exp)
         else $error("buck3 decode wrong");
   bb_rsvd_a:
      assert property (ready_ff && $stable(buckboost_voltage_code_ff) &&
         buckboost_voltage_code_ff > 6'h34 |-> buckboost_reserved_ff && buckboost_mv_ff == 0)
         else $error("reserved code not flagged");
endmodule

bind converter_setpoint_registers setpoint_checker #(.BLANK_CYCLES(BLANK_CYCLES)) chk_inst (
   .clk(clk), .reset_n(reset_n), .ce(ce), .wr_en(wr_en), .rd_en(rd_en), .subaddr(subaddr),
   .wdata(wdata), .write_unlocked(write_unlocked), .ready_ff(ready_ff), .rdata_ff(rdata_ff),
   .wr_done_ff(wr_done_ff), .pulse_skip_enable_ff(pulse_skip_enable_ff),
   .buck3_voltage_code_ff(buck3_voltage_code_ff), .buck3_mv_ff(buck3_mv_ff),
   .buckboost_voltage_code_ff(buckboost_voltage_code_ff), .buckboost_mv_ff(buckboost_mv_ff),
   .buckboost_reserved_ff(buckboost_reserved_ff), .blanking_ff(blanking_ff),
   .ov_out_ff(ov_out_ff), .uv_out_ff(uv_out_ff));

// ---- test/test_converter_setpoint_registers.sv ----
// Directed bench for the converter set-point registers
`timescale 1ns/1ps
module test_converter_setpoint_registers;
   localparam int unsigned BLANK = 20;
   logic        clk = 1'b0, reset_n = 1'b0, ce = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
   logic        write_unlocked = 1'b0, resistor_select = 1'b0;
   logic [7:0]  subaddr = 8'h00, wdata = 8'h00;
   logic [2:0]  ov_in = 3'h0, uv_in = 3'h0;
   logic        wr_done_ff, ready_ff, rsv;
   logic [7:0]  rdata_ff;
   logic [2:0]  pse, blanking_ff, ov_out_ff, uv_out_ff;
   logic [5:0]  c2, c3, c4;
   logic [11:0] m2, m3, m4;
   int          n_errors = 0, compares = 0;

   converter_setpoint_registers #(.BLANK_CYCLES(BLANK)) converter_setpoint_registers_inst (
      .clk(clk), .reset_n(reset_n), .ce(ce), .wr_en(wr_en), .rd_en(rd_en),
      .subaddr(subaddr), .wdata(wdata), .write_unlocked(write_unlocked),
      .resistor_select(resistor_select), .ov_in(ov_in), .uv_in(uv_in),
      .rdata_ff(rdata_ff), .wr_done_ff(wr_done_ff), .ready_ff(ready_ff),
      .pulse_skip_enable_ff(pse), .buck2_voltage_code_ff(c2), .buck3_voltage_code_ff(c3),
      .buckboost_voltage_code_ff(c4), .buck2_mv_ff(m2), .buck3_mv_ff(m3),
      .buckboost_mv_ff(m4), .buckboost_reserved_ff(rsv), .blanking_ff(blanking_ff),
      .ov_out_ff(ov_out_ff), .uv_out_ff(uv_out_ff));

   always #2.5 clk = ~clk;

   task automatic end_of_test;
      if (n_errors == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string what);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask

   function automatic logic [11:0] mv(input int k, input logic [5:0] c);
      if (k == 2)
         return c <= 6'h32 ? 12'd850 + 12'd10 * c : 12'd1375 + 12'd25 * (c - 6'h33);
      if (k == 3)
         return c <= 6'h1a ? 12'd900 + 12'd25 * c : 12'd1600 + 12'd50 * (c - 6'h1b);
      return c > 6'h34 ? 12'd0 : c <= 6'h0f ? 12'd1175 + 12'd25 * c
         : 12'd1600 + 12'd50 * (c - 6'h10);
   endfunction

   task automatic do_reset(input logic rs);
      @(negedge clk);
      reset_n = 1'b0;
      resistor_select = rs;
      repeat (8) @(negedge clk);
      reset_n = 1'b1;
   endtask

   // One-cycle write; reports whether the done pulse followed
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic u, output logic ok);
      @(negedge clk);
      wr_en = 1'b1;
      subaddr = a;
      wdata = d;
      write_unlocked = u;
      @(negedge clk);
      wr_en = 1'b0;
      ok = wr_done_ff;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk);
      rd_en = 1'b1;
      subaddr = a;
      @(negedge clk);
      rd_en = 1'b0;
      d = rdata_ff;
   endtask

   task automatic s_defaults(input logic rs);
      logic       ok;
      logic [7:0] d;
      wr(8'h18, 8'h05, 1'b1, ok);
      chk(ok, 1'b0, "early write");
      for (int i = 0; i < 20 && ready_ff !== 1'b1; i++)
         @(negedge clk);
      @(negedge clk);
      chk(ready_ff, 1'b1, "ready");
      rd(8'h18, d);
      chk(d, rs ? 8'h88 : 8'h8c, "buck3 reset");
      rd(8'h19, d);
      chk(d, rs ? 8'h94 : 8'hb2, "buckboost reset");
      chk(pse, 3'b111, "pulse skip reset");
      chk(m3, rs ? 12'd1100 : 12'd1200, "buck3 reset mv");
      chk(m4, rs ? 12'd1800 : 12'd3300, "buckboost reset mv");
   endtask

   task automatic s_lock;
      logic       ok;
      logic [7:0] d;
      wr(8'h18, 8'h85, 1'b0, ok);
      chk(ok, 1'b0, "locked write");
      ce = 1'b0;
      wr(8'h18, 8'h85, 1'b1, ok);
      ce = 1'b1;
      chk(ok, 1'b0, "frozen write");
      wr(8'h1a, 8'h85, 1'b1, ok);
      chk(ok, 1'b0, "unmapped write");
      rd(8'h1a, d);
      chk(d, 8'h00, "unmapped read");
      rd(8'h18, d);
      chk(d, 8'h8c, "buck3 kept");
   endtask

   // Boundary codes of each map; bit 6 always written high, bit 7 alternates
   task automatic s_codes;
      int         k [13] = '{2, 2, 2, 2, 3, 3, 3, 3, 4, 4, 4, 4, 4};
      logic [5:0] c [13] = '{6'h24, 6'h32, 6'h33, 6'h3f, 6'h00, 6'h1a, 6'h1b, 6'h3f,
                             6'h00, 6'h0f, 6'h10, 6'h34, 6'h35};
      logic       ok;
      logic [7:0] d, a;
      for (int i = 0; i < 13; i++) begin
         a = 8'h15 + 8'(k[i]);
         // host rules, broken only by row 12 on purpose
         wr(a, {i[0], 1'b1, c[i]}, 1'b1, ok);
         @(negedge clk);
         rd(a, d);
         chk(ok, 1'b1, "write taken");
         chk(d, {i[0], 1'b0, c[i]}, "read back");
         chk(pse[k[i] - 2], i[0], "pulse skip");
         chk(k[i] == 2 ? m2 : k[i] == 3 ? m3 : m4, mv(k[i], c[i]), "mv");
         chk(k[i] == 2 ? c2 : k[i] == 3 ? c3 : c4, c[i], "code out");
      end
      chk(rsv, 1'b1, "reserved flag");
      wr(8'h19, 8'hb2, 1'b1, ok);
   endtask

   task automatic s_blank;
      logic ok;
      int   n;
      ov_in = 3'b111;
      uv_in = 3'b111;
      repeat (BLANK + 8) @(negedge clk);
      chk(ov_out_ff, 3'b111, "monitor pass");
      wr(8'h18, 8'h8c, 1'b1, ok);
      chk(blanking_ff, 3'b010, "buck3 blank");
      chk(uv_out_ff, 3'b101, "buck3 masked");
      wr(8'h19, 8'hb2, 1'b1, ok);
      repeat (8) @(negedge clk);
      wr(8'h19, 8'hb2, 1'b1, ok);
      n = 0;
      while (blanking_ff[2] === 1'b1 && n < 100) begin
         n++;
         @(negedge clk);
      end
      chk(n, BLANK + 1, "blank length");
      repeat (4) @(negedge clk);
      chk(ov_out_ff, 3'b111, "monitor back");
   endtask

   initial begin
      do_reset(1'b1);
      s_defaults(1'b1);
      do_reset(1'b0);
      s_defaults(1'b0);
      s_lock();
      s_codes();
      s_blank();
      end_of_test();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      #50000;
      n_errors++;
      end_of_test();
   end
endmodule

// ---- verilog/blank_timer.sv ----
// Retriggerable interval timer that holds a blanking level for a fixed cycle count
`timescale 1ns/1ps

module blank_timer #(
   parameter int unsigned CYCLES = 1000000
) (
   input  wire logic clk,
   input  wire logic reset_n,
   input  wire logic ce,
   input  wire logic start,
   output logic      busy_ff
);

   localparam int unsigned CNT_W = $clog2(CYCLES + 1);

   if (CYCLES < 1) begin : g_bad_cycles
      $error("blank_timer needs CYCLES of at least 1");
   end

   logic [CNT_W-1:0] cnt_ff;

   // A new start restarts the full interval even if one is running
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         cnt_ff  <= '0;
         busy_ff <= 1'b0;
      end else if (ce) begin
         if (start) begin
            cnt_ff  <= CNT_W'(CYCLES - 1);
            busy_ff <= 1'b1;
         end else if (busy_ff) begin
            if (cnt_ff == '0)
               busy_ff <= 1'b0;
            else
               cnt_ff <= cnt_ff - 1'b1;
         end
      end
   end

endmodule

// ---- verilog/converter_setpoint_registers.sv ----
// Set-point registers, code decode and monitor blanking for the converters
//
// What this block and its host must do
// RQ1: Buck2 codes 24h-32h decode in 10 mV steps from 1.210 V and 33h-3Fh in 25 mV steps to 1.675 V.
// RQ2: Buck3 set-point sits at subaddress 0x18, resets to 0x8C, pulse-skip in bit 7, code in bits 5-0.
// RQ3: Buck3 code resets to Ch and maps 0h-1Ah from 0.900 V by 25 mV and 1Bh-3Fh by 50 mV to 3.400 V.
// RQ4: Buck-boost set-point sits at 0x19, resets to 0xB2, pulse-skip in bit 7, code 32h in bits 5-0.
// RQ5: Bit 7 is a read-write pulse-skip enable resetting to 1; 0 forces PWM, 1 allows skipping.
// RQ6: Writes change these registers only when the password mechanism unlocks them.
// RQ7: Every accepted buck3 write blanks its over/undervoltage monitoring for 5 ms.
// RQ8: Every accepted buck-boost write blanks its over/undervoltage monitoring for 5 ms.
// RQ9: The power-up buck3 and buck-boost codes may follow the resistor-select strap.
// RQ10: The host must never write a reserved buck-boost code.
// RQ11: The host must change the buck-boost code only while that converter is disabled.
// RQ12: Buck-boost codes map from 1.175 V by 25 mV to Fh, by 50 mV to 3.400 V at 34h; 35h-3Fh reserved.
// RQ13: Bit 6 always reads 0 and ignores writes.
`timescale 1ns/1ps
`include "setpoint_cfg.svh"

module converter_setpoint_registers
   import setpoint_pkg::*;
#(
   parameter int unsigned        BLANK_CYCLES       = `BLANK_CYCLES,
   parameter logic [`CODE_W-1:0] BUCK3_ALT_CODE     = 6'h08,
   parameter logic [`CODE_W-1:0] BUCKBOOST_ALT_CODE = 6'h14
) (
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire logic                   ce,
   input  wire logic                   wr_en,
   input  wire logic                   rd_en,
   input  wire logic [`SUBADDR_W-1:0]  subaddr,
   input  wire logic [`DATA_W-1:0]     wdata,
   input  wire logic                   write_unlocked,
   input  wire logic                   resistor_select,
   input  wire logic [2:0]             ov_in,
   input  wire logic [2:0]             uv_in,
   output logic      [`DATA_W-1:0]     rdata_ff,
   output logic                        wr_done_ff,
   output logic                        ready_ff,
   output logic      [2:0]             pulse_skip_enable_ff,
   output logic      [`CODE_W-1:0]     buck2_voltage_code_ff,
   output logic      [`CODE_W-1:0]     buck3_voltage_code_ff,
   output logic      [`CODE_W-1:0]     buckboost_voltage_code_ff,
   output logic      [`MV_W-1:0]       buck2_mv_ff,
   output logic      [`MV_W-1:0]       buck3_mv_ff,
   output logic      [`MV_W-1:0]       buckboost_mv_ff,
   output logic                        buckboost_reserved_ff,
   output logic      [2:0]             blanking_ff,
   output logic      [2:0]             ov_out_ff,
   output logic      [2:0]             uv_out_ff
);

   if (BLANK_CYCLES < 1) begin : g_bad_blank
      $error("BLANK_CYCLES must be at least 1");
   end

   // RQ12 strap alternate legal
   // A reserved alternate would power up into a flagged, meaningless set-point
   if (BUCKBOOST_ALT_CODE > `BB_TOP_CODE) begin : g_bad_alt
      $error("BUCKBOOST_ALT_CODE must not be a reserved code");
   end

   // Converter index: 0 buck2, 1 buck3, 2 buck-boost
   localparam int unsigned NCONV = 3;

   // Reset images, split into fields by position rather than by shifting
   localparam logic [`DATA_W-1:0] BUCK2_RST     = `BUCK2_RESET;
   localparam logic [`DATA_W-1:0] BUCK3_RST     = `BUCK3_RESET;
   localparam logic [`DATA_W-1:0] BUCKBOOST_RST = `BUCKBOOST_RESET;

   strap_state_t       strap_state_ff;
   strap_state_t       nxt_strap_state;
   logic [1:0]         strap_cnt_ff;
   logic               resistor_select_meta_ff;
   logic               resistor_select_sync_ff;
   logic [2:0]         ov_meta_ff;
   logic [2:0]         ov_sync_ff;
   logic [2:0]         uv_meta_ff;
   logic [2:0]         uv_sync_ff;
   logic               wr_ok;
   logic [NCONV-1:0]   wr_hit;
   logic [NCONV-1:0]   blank_busy;
   logic [`MV_W-1:0]   mv_dec [NCONV];
   logic [NCONV-1:0]   rsvd_dec;

   // Register image as software sees it; bit 6 is never stored
   function automatic logic [`DATA_W-1:0] reg_image(
      input logic             pse,
      input logic [`CODE_W-1:0] code
   );
      logic [`DATA_W-1:0] v;
      v                      = '0;
      v[`PSE_BIT]            = pse;
      v[`CODE_MSB:`CODE_LSB] = code;
      reg_image              = v;
   endfunction

   // Pin synchronisers; the first stage feeds only the second
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         resistor_select_meta_ff <= 1'b0;
         resistor_select_sync_ff <= 1'b0;
         ov_meta_ff   <= '0;
         ov_sync_ff   <= '0;
         uv_meta_ff   <= '0;
         uv_sync_ff   <= '0;
      end else if (ce) begin
         resistor_select_meta_ff <= resistor_select;
         resistor_select_sync_ff <= resistor_select_meta_ff;
         ov_meta_ff   <= ov_in;
         ov_sync_ff   <= ov_meta_ff;
         uv_meta_ff   <= uv_in;
         uv_sync_ff   <= uv_meta_ff;
      end
   end

   // RQ9 strap capture sequence
   always_comb begin
      nxt_strap_state = strap_state_ff;
      unique case (strap_state_ff)
         STRAP_WAIT: begin
            if (strap_cnt_ff == `STRAP_SETTLE)
               nxt_strap_state = STRAP_LOAD;
         end
         STRAP_LOAD: begin
            nxt_strap_state = STRAP_DONE;
         end
         STRAP_DONE: begin
            nxt_strap_state = STRAP_DONE;
         end
         default: begin
            nxt_strap_state = STRAP_WAIT;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         strap_state_ff <= STRAP_WAIT;
         strap_cnt_ff   <= 2'h0;
      end else if (ce) begin
         strap_state_ff <= nxt_strap_state;
         if (strap_state_ff == STRAP_WAIT)
            strap_cnt_ff <= strap_cnt_ff + 2'h1;
      end
   end

   // RQ9 writes open after load
   // Gating writes on this keeps the strap load from overwriting a host value
   always_ff @(posedge clk) begin
      if (!reset_n)
         ready_ff <= 1'b0;
      else if (ce)
         ready_ff <= (nxt_strap_state == STRAP_DONE);
   end

   // RQ6 password gate
   // Writes are also held off until the strap defaults have landed
   assign wr_ok     = wr_en && write_unlocked && ready_ff;
   assign wr_hit[0] = wr_ok && (subaddr == `BUCK2_SUBADDR);
   assign wr_hit[1] = wr_ok && (subaddr == `BUCK3_SUBADDR);
   assign wr_hit[2] = wr_ok && (subaddr == `BUCKBOOST_SUBADDR);

   // RQ2 RQ4 RQ5 register storage
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pulse_skip_enable_ff[0]   <= BUCK2_RST[`PSE_BIT];
         pulse_skip_enable_ff[1]   <= BUCK3_RST[`PSE_BIT];
         pulse_skip_enable_ff[2]   <= BUCKBOOST_RST[`PSE_BIT];
         buck2_voltage_code_ff     <= BUCK2_RST[`CODE_MSB:`CODE_LSB];
         buck3_voltage_code_ff     <= BUCK3_RST[`CODE_MSB:`CODE_LSB];
         buckboost_voltage_code_ff <= BUCKBOOST_RST[`CODE_MSB:`CODE_LSB];
      end else if (ce) begin
         // RQ9 strap default load
         if (strap_state_ff == STRAP_LOAD && resistor_select_sync_ff) begin
            buck3_voltage_code_ff     <= BUCK3_ALT_CODE;
            buckboost_voltage_code_ff <= BUCKBOOST_ALT_CODE;
         end
         // RQ13 bit 6 dropped
         if (wr_hit[0]) begin
            pulse_skip_enable_ff[0] <= wdata[`PSE_BIT];
            buck2_voltage_code_ff   <= wdata[`CODE_MSB:`CODE_LSB];
         end
         if (wr_hit[1]) begin
            pulse_skip_enable_ff[1] <= wdata[`PSE_BIT];
            buck3_voltage_code_ff   <= wdata[`CODE_MSB:`CODE_LSB];
         end
         // RQ4 buck-boost field update
         if (wr_hit[2]) begin
            pulse_skip_enable_ff[2]   <= wdata[`PSE_BIT];
            buckboost_voltage_code_ff <= wdata[`CODE_MSB:`CODE_LSB];
         end
      end
   end

   // RQ6 accepted-write acknowledge
   always_ff @(posedge clk) begin
      if (!reset_n)
         wr_done_ff <= 1'b0;
      else if (ce)
         wr_done_ff <= |wr_hit;
   end

   // RQ13 read path, bit 6 reads 0
   // Unmapped subaddresses read as zero
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         rdata_ff <= '0;
      end else if (ce) begin
         if (rd_en) begin
            unique case (subaddr)
               `BUCK2_SUBADDR:
                  rdata_ff <= reg_image(pulse_skip_enable_ff[0], buck2_voltage_code_ff);
               `BUCK3_SUBADDR:
                  rdata_ff <= reg_image(pulse_skip_enable_ff[1], buck3_voltage_code_ff);
               `BUCKBOOST_SUBADDR:
                  rdata_ff <= reg_image(pulse_skip_enable_ff[2], buckboost_voltage_code_ff);
               default:
                  rdata_ff <= '0;
            endcase
         end
      end
   end

   // RQ1 buck2 decode
   voltage_decode #(
      .KIND       (KIND_BUCK2)
   ) u_dec_buck2 (
      .code       (buck2_voltage_code_ff),
      .millivolts (mv_dec[0]),
      .reserved   (rsvd_dec[0])
   );

   // RQ3 buck3 decode
   voltage_decode #(
      .KIND       (KIND_BUCK3)
   ) u_dec_buck3 (
      .code       (buck3_voltage_code_ff),
      .millivolts (mv_dec[1]),
      .reserved   (rsvd_dec[1])
   );

   // RQ12 buck-boost decode
   voltage_decode #(
      .KIND       (KIND_BUCKBOOST)
   ) u_dec_buckboost (
      .code       (buckboost_voltage_code_ff),
      .millivolts (mv_dec[2]),
      .reserved   (rsvd_dec[2])
   );

   // RQ1 RQ3 RQ12 decoded millivolts
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         buck2_mv_ff     <= '0;
         buck3_mv_ff     <= '0;
         buckboost_mv_ff <= '0;
      end else if (ce) begin
         buck2_mv_ff     <= mv_dec[0];
         buck3_mv_ff     <= mv_dec[1];
         buckboost_mv_ff <= mv_dec[2];
      end
   end

   // RQ12 reserved code flagged
   // Flagged rather than clamped so software can see its own mistake
   always_ff @(posedge clk) begin
      if (!reset_n)
         buckboost_reserved_ff <= 1'b0;
      else if (ce)
         buckboost_reserved_ff <= rsvd_dec[2];
   end

   // RQ7 RQ8 blanking timers, one per converter
   for (genvar i = 0; i < NCONV; i++) begin : g_blank
      blank_timer #(
         .CYCLES  (BLANK_CYCLES)
      ) u_blank (
         .clk     (clk),
         .reset_n (reset_n),
         .ce      (ce),
         .start   (wr_hit[i]),
         .busy_ff (blank_busy[i])
      );
   end

   // RQ7 RQ8 monitor masking
   // Start is also masked so results never leak on the write cycle itself
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         blanking_ff <= '0;
         ov_out_ff   <= '0;
         uv_out_ff   <= '0;
      end else if (ce) begin
         blanking_ff <= blank_busy | wr_hit;
         ov_out_ff   <= ov_sync_ff & ~(blank_busy | wr_hit);
         uv_out_ff   <= uv_sync_ff & ~(blank_busy | wr_hit);
      end
   end

   logic unused_rsvd;
   assign unused_rsvd = rsvd_dec[0] | rsvd_dec[1];

endmodule

// ---- verilog/voltage_decode.sv ----
// Maps a 6-bit converter voltage code to millivolts for one converter kind
`timescale 1ns/1ps
`include "setpoint_cfg.svh"

module voltage_decode
   import setpoint_pkg::*;
#(
   parameter conv_kind_t KIND = KIND_BUCK2
) (
   input  wire logic [`CODE_W-1:0] code,
   output logic      [`MV_W-1:0]   millivolts,
   output logic                    reserved
);

   // Two linear segments joined at a knee code
   function automatic logic [`MV_W-1:0] two_seg(
      input logic [`CODE_W-1:0] c,
      input logic [`CODE_W-1:0] knee,
      input logic [`MV_W-1:0]   base,
      input logic [`MV_W-1:0]   step1,
      input logic [`MV_W-1:0]   high,
      input logic [`MV_W-1:0]   step2
   );
      logic [`CODE_W-1:0] over;
      over = c - knee - 6'h01;
      if (c <= knee)
         two_seg = base + step1 * {6'h00, c};
      else
         two_seg = high + step2 * {6'h00, over};
   endfunction

   always_comb begin
      reserved   = 1'b0;
      millivolts = '0;
      unique case (KIND)
         KIND_BUCK2: begin
            millivolts = two_seg(code, `BUCK2_KNEE, `BUCK2_BASE_MV, `BUCK2_STEP1_MV,
                                 `BUCK2_HIGH_MV, `BUCK2_STEP2_MV);
         end
         KIND_BUCK3: begin
            millivolts = two_seg(code, `BUCK3_KNEE, `BUCK3_BASE_MV, `BUCK3_STEP1_MV,
                                 `BUCK3_HIGH_MV, `BUCK3_STEP2_MV);
         end
         KIND_BUCKBOOST: begin
            // Reserved codes report 0 mV so nothing downstream acts on them
            if (code > `BB_TOP_CODE) begin
               reserved = 1'b1;
            end else begin
               millivolts = two_seg(code, `BB_KNEE, `BB_BASE_MV, `BB_STEP1_MV,
                                    `BB_HIGH_MV, `BB_STEP2_MV);
            end
         end
         default: begin
            reserved = 1'b1;
         end
      endcase
   end

endmodule
